// ---- logic/efc_pkg.sv ----
// constants, types and code functions for the ecc queue
package efc_pkg;

	// ------------------------------------------------------------
	// code word geometry
	// ------------------------------------------------------------
	localparam int EFC_DATA_W  = 64;
	localparam int EFC_CODE_W  = 72;
	localparam int EFC_SYN_W   = 7;
	// injected faults land on two fixed data positions of the code word
	localparam int EFC_INJ_POS_A = 3;
	localparam int EFC_INJ_POS_B = 5;

	// ------------------------------------------------------------
	// organisations
	// ------------------------------------------------------------
	typedef enum logic [0:0] {
		EFC_ORG_PTR   = 1'b0,
		EFC_ORG_SHIFT = 1'b1
	} efc_org_t;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic [EFC_CODE_W-1:0] efc_encode(input logic [EFC_DATA_W-1:0] d);
		logic [EFC_CODE_W-1:0] c;
		int                    j;
		c = '0;
		j = 0;
		for (int i = 1; i < EFC_CODE_W; i++) begin
			if ((i & (i - 1)) != 0) begin
				c[i] = d[j];
				j++;
			end
		end
		for (int k = 0; k < EFC_SYN_W; k++) begin
			for (int i = 1; i < EFC_CODE_W; i++) begin
				if (i[k] && (i != (1 << k))) begin
					c[1 << k] = c[1 << k] ^ c[i];
				end
			end
		end
		c[0] = ^c[EFC_CODE_W-1:1];
		return c;
	endfunction : efc_encode

	function automatic logic [EFC_SYN_W-1:0] efc_syndrome(input logic [EFC_CODE_W-1:0] c);
		logic [EFC_SYN_W-1:0] s;
		s = '0;
		for (int i = 1; i < EFC_CODE_W; i++) begin
			if (c[i]) begin
				s = s ^ i[EFC_SYN_W-1:0];
			end
		end
		return s;
	endfunction : efc_syndrome

	function automatic logic [EFC_DATA_W-1:0] efc_extract(input logic [EFC_CODE_W-1:0] c);
		logic [EFC_DATA_W-1:0] d;
		int                    j;
		d = '0;
		j = 0;
		for (int i = 1; i < EFC_CODE_W; i++) begin
			if ((i & (i - 1)) != 0) begin
				d[j] = c[i];
				j++;
			end
		end
		return d;
	endfunction : efc_extract

	function automatic logic [EFC_CODE_W-1:0] efc_flip(input logic [EFC_CODE_W-1:0] c,
		input logic [EFC_SYN_W-1:0] pos);
		logic [EFC_CODE_W-1:0] r;
		r = c;
		if (int'(pos) < EFC_CODE_W) begin
			r[pos] = ~r[pos];
		end
		return r;
	endfunction : efc_flip

	function automatic logic [EFC_SYN_W:0] efc_gray(input logic [EFC_SYN_W:0] b);
		return b ^ (b >> 1);
	endfunction : efc_gray

	function automatic logic [EFC_SYN_W:0] efc_bin(input logic [EFC_SYN_W:0] g);
		logic [EFC_SYN_W:0] b;
		b = '0;
		for (int i = EFC_SYN_W; i >= 0; i--) begin
			b[i] = (i == EFC_SYN_W) ? g[i] : (b[i+1] ^ g[i]);
		end
		return b;
	endfunction : efc_bin

endpackage : efc_pkg

// ---- logic/efc_fifo.sv ----
// ecc protected queue, pointer or shift-register organisation, one clock
//
// Behaviour
// - code and injection only in memory organisation; injection needs code enabled.
// - single and double error flags encode clean, corrected or detected.
// - corrected data goes out; the stored faulty word stays unchanged.
// - each error flag is the OR over all cascaded primitives.
// - error flags come combinationally from the primitive flags.
// - write side pointers pass a crossing stage before feeding read flags.
// - two write inputs request no, single or double injection.
// - code spans 64-bit words; spare bit faults may raise double error.
// - single injection stores one bit error, flagged single on readback.
// - double injection stores two bit error, flagged double on readback.
// - both injection inputs high give a double error only.
// - reset leaves read data and error flags holding their values.
// - pointer crossing makes no assumption about the clock relation.
// - write signals belong to write side, read signals to read side.
// - separate pointers pass between sides as gray code.
// - empty clears after the pointer crossing latency, not a fixed count.
// - depth splits over primitives of PRIM_DEPTH words each.
// - common clock variant behaves as the dual side variant.
// - memory variant keeps two pointer counters on one clock, sync reset.
// - shift variant uses one up/down counter for all flags.
`timescale 1ns/10ps
module efc_fifo
	import efc_pkg::*;
#(
	parameter int       DATA_W     = 16,
	parameter int       DEPTH      = 64,
	parameter int       PRIM_DEPTH = 16,
	parameter efc_org_t ORG        = EFC_ORG_PTR,
	parameter bit       ECC_EN     = 1'b1,
	parameter bit       INJ_EN     = 1'b1,
	parameter int       FULL_THR   = 48,
	parameter int       EMPTY_THR  = 4
) (
	input  wire logic              clock_i,
	input  wire logic              sys_rst_i,
	input  wire logic              wr_en_i,
	input  wire logic [DATA_W-1:0] wr_data_i,
	input  wire logic              inject_one_bit_fault_i,
	input  wire logic              inject_two_bit_fault_i,
	output logic                   full_o,
	output logic                   near_full_flag_o,
	output logic                   threshold_full_flag_o,
	output logic                   wr_ack_o,
	output logic                   overflow_o,
	output logic [$clog2(DEPTH):0] wr_count_o,
	input  wire logic              rd_en_i,
	output logic [DATA_W-1:0]      rd_data_o,
	output logic                   empty_o,
	output logic                   near_empty_flag_o,
	output logic                   threshold_empty_flag_o,
	output logic                   valid_o,
	output logic                   underflow_o,
	output logic [$clog2(DEPTH):0] rd_count_o,
	output logic                   single_error_flag_o,
	output logic                   double_error_flag_o
);

	// ------------------------------------------------------------
	// configuration checks
	// ------------------------------------------------------------
	localparam int AW    = $clog2(DEPTH);
	localparam int PRIMS = DEPTH / PRIM_DEPTH;

	if (DATA_W < 1 || DATA_W > EFC_DATA_W) begin : g_bad_width
		$error("data width must be 1 to 64");
	end
	if (DEPTH < 4 || (1 << AW) != DEPTH || AW > EFC_SYN_W) begin : g_bad_depth
		$error("depth must be a power of two from 4 to 128");
	end
	if (PRIM_DEPTH < 1 || PRIMS * PRIM_DEPTH != DEPTH) begin : g_bad_prim
		$error("primitive depth must divide depth");
	end
	if ((INJ_EN && !ECC_EN) || (ECC_EN && ORG == EFC_ORG_SHIFT)) begin : g_bad_ecc
		$error("code needs memory organisation, injection needs code");
	end
	if (FULL_THR < 1 || FULL_THR > DEPTH || EMPTY_THR < 0 || EMPTY_THR >= DEPTH) begin : g_bad_thr
		$error("thresholds out of range");
	end

	localparam logic [AW:0] LVL_DEPTH = (AW+1)'(DEPTH);
	localparam logic [AW:0] LVL_NFULL = (AW+1)'(DEPTH - 1);
	localparam logic [AW:0] LVL_TFULL = (AW+1)'(FULL_THR);
	localparam logic [AW:0] LVL_TEMPT = (AW+1)'(EMPTY_THR);
	localparam logic [AW:0] LVL_ONE   = (AW+1)'(1);
	localparam logic [AW:0] LVL_ZERO  = '0;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [EFC_CODE_W-1:0] mem [DEPTH];
	logic [AW:0]           wptr;
	logic [AW:0]           rptr;
	logic [AW:0]           wgray;
	logic [AW:0]           rgray;
	logic [AW:0]           wgray_r;
	logic [AW:0]           rgray_w;
	logic [AW:0]           occ;
	logic [EFC_CODE_W-1:0] rd_word;
	logic [AW-1:0]         rd_addr;

	// ------------------------------------------------------------
	// acceptance
	// ------------------------------------------------------------
	wire wr_ok = wr_en_i & ~full_o;
	wire rd_ok = rd_en_i & ~empty_o;

	wire [AW:0] next_wptr = wptr + (AW+1)'(wr_ok);
	wire [AW:0] next_rptr = rptr + (AW+1)'(rd_ok);
	wire [AW:0] next_occ  = occ + (AW+1)'(wr_ok) - (AW+1)'(rd_ok);

	// gray pointers cross through a stage; conversion back is local
	wire [AW:0] rbin_w = (AW+1)'(efc_bin((EFC_SYN_W+1)'(rgray_w)));
	wire [AW:0] wbin_r = (AW+1)'(efc_bin((EFC_SYN_W+1)'(wgray_r)));

	// stale far pointers only make the levels pessimistic
	wire [AW:0] next_wr_lvl = (ORG == EFC_ORG_SHIFT) ? next_occ : (next_wptr - rbin_w);
	wire [AW:0] next_rd_lvl = (ORG == EFC_ORG_SHIFT) ? next_occ : (wbin_r - next_rptr);

	wire [AW-1:0] rd_idx = (ORG == EFC_ORG_SHIFT) ? AW'(occ - LVL_ONE) : rptr[AW-1:0];

	// ------------------------------------------------------------
	// write encoding and injection
	// ------------------------------------------------------------
	wire [EFC_CODE_W-1:0] enc_word = efc_encode(EFC_DATA_W'(wr_data_i));
	wire                  inj_two  = INJ_EN & inject_two_bit_fault_i;
	wire                  inj_one  = INJ_EN & inject_one_bit_fault_i & ~inj_two;
	wire [EFC_CODE_W-1:0] inj_a    = efc_flip(enc_word, EFC_SYN_W'(EFC_INJ_POS_A));
	wire [EFC_CODE_W-1:0] inj_ab   = efc_flip(inj_a, EFC_SYN_W'(EFC_INJ_POS_B));
	wire [EFC_CODE_W-1:0] st_word  = inj_two ? inj_ab : (inj_one ? inj_a : enc_word);

	// ------------------------------------------------------------
	// memory, never reset
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (ORG == EFC_ORG_SHIFT) begin
			if (wr_ok && !sys_rst_i) begin
				mem[0] <= st_word;
				for (int i = 1; i < DEPTH; i++) begin
					mem[i] <= mem[i-1];
				end
			end
		end else if (wr_ok && !sys_rst_i) begin
			mem[wptr[AW-1:0]] <= st_word;
		end
	end

	// read word holds through reset; the array itself is never rewritten
	always_ff @(posedge clock_i) begin
		if (rd_ok && !sys_rst_i) begin
			rd_word <= mem[rd_idx];
			rd_addr <= rd_idx;
		end
	end

	// ------------------------------------------------------------
	// pointers and crossing stages
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			wptr    <= '0;
			rptr    <= '0;
			wgray   <= '0;
			rgray   <= '0;
			wgray_r <= '0;
			rgray_w <= '0;
			occ     <= '0;
		end else begin
			wptr    <= next_wptr;
			rptr    <= next_rptr;
			wgray   <= (AW+1)'(efc_gray((EFC_SYN_W+1)'(next_wptr)));
			rgray   <= (AW+1)'(efc_gray((EFC_SYN_W+1)'(next_rptr)));
			wgray_r <= wgray;
			rgray_w <= rgray;
			occ     <= next_occ;
		end
	end

	// ------------------------------------------------------------
	// write side status
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			full_o                <= 1'b0;
			near_full_flag_o      <= 1'b0;
			threshold_full_flag_o <= 1'b0;
			wr_ack_o              <= 1'b0;
			overflow_o            <= 1'b0;
			wr_count_o            <= '0;
		end else begin
			full_o                <= (next_wr_lvl == LVL_DEPTH);
			near_full_flag_o      <= (next_wr_lvl >= LVL_NFULL);
			threshold_full_flag_o <= (next_wr_lvl >= LVL_TFULL);
			wr_ack_o              <= wr_ok;
			overflow_o            <= wr_en_i & full_o;
			wr_count_o            <= next_wr_lvl;
		end
	end

	// ------------------------------------------------------------
	// read side status
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			empty_o                <= 1'b1;
			near_empty_flag_o      <= 1'b1;
			threshold_empty_flag_o <= 1'b1;
			valid_o                <= 1'b0;
			underflow_o            <= 1'b0;
			rd_count_o             <= '0;
		end else begin
			empty_o                <= (next_rd_lvl == LVL_ZERO);
			near_empty_flag_o      <= (next_rd_lvl <= LVL_ONE);
			threshold_empty_flag_o <= (next_rd_lvl <= LVL_TEMPT);
			valid_o                <= rd_ok;
			underflow_o            <= rd_en_i & empty_o;
			rd_count_o             <= next_rd_lvl;
		end
	end

	// ------------------------------------------------------------
	// decode, combinational to the ports
	// ------------------------------------------------------------
	// the flags must not be registered, so they and the data leave the read word directly
	wire [EFC_SYN_W-1:0]  syn      = efc_syndrome(rd_word);
	wire                  par_err  = ^rd_word;
	wire                  one_err  = par_err;
	wire                  two_err  = ~par_err & (syn != '0);
	wire [EFC_CODE_W-1:0] fix_word = one_err ? efc_flip(rd_word, syn) : rd_word;
	wire [EFC_DATA_W-1:0] fix_data = efc_extract(fix_word);
	wire [EFC_DATA_W-1:0] raw_data = efc_extract(rd_word);

	// per primitive flags; only the primitive last read reports here
	wire [PRIMS-1:0] prim_one;
	wire [PRIMS-1:0] prim_two;
	for (genvar p = 0; p < PRIMS; p++) begin : g_prim
		wire hit = ((int'(rd_addr) / PRIM_DEPTH) == p);
		assign prim_one[p] = ECC_EN & hit & one_err;
		assign prim_two[p] = ECC_EN & hit & two_err;
	end

	assign single_error_flag_o = |prim_one;
	assign double_error_flag_o = |prim_two;
	assign rd_data_o = ECC_EN ? DATA_W'(fix_data) : DATA_W'(raw_data);

endmodule : efc_fifo

// ---- test/efc_fifo_monitor.sv ----
// port checker for the ecc queue
`timescale 1ns/10ps
module efc_fifo_monitor #(
	parameter int DATA_W = 16,
	parameter int DEPTH  = 64
) (
	input wire logic                   clock_i,
	input wire logic                   sys_rst_i,
	input wire logic                   wr_en_i,
	input wire logic                   rd_en_i,
	input wire logic                   full_o,
	input wire logic                   near_full_flag_o,
	input wire logic                   threshold_full_flag_o,
	input wire logic                   wr_ack_o,
	input wire logic                   overflow_o,
	input wire logic [$clog2(DEPTH):0] wr_count_o,
	input wire logic [DATA_W-1:0]      rd_data_o,
	input wire logic                   empty_o,
	input wire logic                   near_empty_flag_o,
	input wire logic                   threshold_empty_flag_o,
	input wire logic                   valid_o,
	input wire logic                   underflow_o,
	input wire logic [$clog2(DEPTH):0] rd_count_o,
	input wire logic                   single_error_flag_o,
	input wire logic                   double_error_flag_o
);
	// ------
	// checks
	// ------
	logic seen;
	always_ff @(posedge clock_i) begin
		if (valid_o) begin
			seen <= 1'b1;
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	property p_ack; wr_en_i && !full_o |=> wr_ack_o && !overflow_o; endproperty
	a_ack: assert property (p_ack) else $error("write not acknowledged");
	property p_ovf; wr_en_i && full_o |=> overflow_o && !wr_ack_o; endproperty
	a_ovf: assert property (p_ovf) else $error("full write not refused");
	property p_rd; rd_en_i && !empty_o |=> valid_o && !underflow_o; endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	property p_unf; rd_en_i && empty_o |=> underflow_o && !valid_o; endproperty
	a_unf: assert property (p_unf) else $error("empty read not refused");
	property p_idle; !wr_en_i && !rd_en_i |=> !(wr_ack_o || overflow_o || valid_o || underflow_o); endproperty
	a_idle: assert property (p_idle) else $error("pulse without request");
	property p_hold;
		disable iff (1'b0) seen && !valid_o |-> $stable(rd_data_o) && $stable(single_error_flag_o)
			&& $stable(double_error_flag_o);
	endproperty
	a_hold: assert property (p_hold) else $error("read word or flag moved");
	property p_excl; seen |-> !(single_error_flag_o && double_error_flag_o); endproperty
	a_excl: assert property (p_excl) else $error("both error flags high");
	property p_elvl; empty_o |-> near_empty_flag_o && threshold_empty_flag_o; endproperty
	a_elvl: assert property (p_elvl) else $error("empty flags disagree");
	property p_flvl; full_o |-> near_full_flag_o && threshold_full_flag_o; endproperty
	a_flvl: assert property (p_flvl) else $error("full flags disagree");
	property p_rst;
		disable iff (1'b0) sys_rst_i |=> empty_o && !full_o && !valid_o && wr_count_o == 0 && rd_count_o == 0;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	c_ovf: cover property (overflow_o);
	c_one: cover property (single_error_flag_o);
	c_two: cover property (double_error_flag_o);
endmodule : efc_fifo_monitor

bind efc_fifo efc_fifo_monitor #(.DATA_W(DATA_W), .DEPTH(DEPTH)) i_mon (
	.clock_i(clock_i), .sys_rst_i(sys_rst_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
	.full_o(full_o), .near_full_flag_o(near_full_flag_o), .threshold_full_flag_o(threshold_full_flag_o),
	.wr_ack_o(wr_ack_o), .overflow_o(overflow_o), .wr_count_o(wr_count_o), .rd_data_o(rd_data_o),
	.empty_o(empty_o), .near_empty_flag_o(near_empty_flag_o), .threshold_empty_flag_o(threshold_empty_flag_o),
	.valid_o(valid_o), .underflow_o(underflow_o), .rd_count_o(rd_count_o),
	.single_error_flag_o(single_error_flag_o), .double_error_flag_o(double_error_flag_o)
);

// ---- test/efc_user.sv ----
// model of the writing and reading user logic
`timescale 1ns/10ps
module efc_user (
	input  wire logic   clock_i,
	output logic        wr_en_o,
	output logic [15:0] wr_data_o,
	output logic        inj_one_o,
	output logic        inj_two_o,
	output logic        rd_en_o
);
	// ------
	// drivers
	// ------
	initial begin
		{wr_en_o, inj_one_o, inj_two_o, rd_en_o} = 4'h0;
		wr_data_o = 16'h0000;
	end
	task automatic put(input logic [15:0] d, input logic i1, input logic i2);
		@(posedge clock_i);
		wr_en_o   <= 1'b1;
		wr_data_o <= d;
		inj_one_o <= i1;
		inj_two_o <= i2;
		@(posedge clock_i);
		wr_en_o   <= 1'b0;
		wr_data_o <= ~d; // no stale word on a released bus
		inj_one_o <= 1'b0;
		inj_two_o <= 1'b0;
	endtask : put
	task automatic burst(input int n, input logic [15:0] d0);
		@(posedge clock_i);
		wr_en_o   <= 1'b1;
		wr_data_o <= d0;
		for (int i = 1; i <= n; i++) begin
			@(posedge clock_i);
			wr_data_o <= d0 + 16'(i);
		end
		wr_en_o <= 1'b0;
	endtask : burst
	// flags belong to the word last read and hold until the next read
	task automatic get();
		@(posedge clock_i);
		rd_en_o <= 1'b1;
		@(posedge clock_i);
		rd_en_o <= 1'b0;
	endtask : get
endmodule : efc_user

// ---- test/tb.sv ----
// self-checking bench for the ecc queue
`timescale 1ns/10ps
module tb;
	typedef struct {
		logic [15:0] d;
		logic        i1;
		logic        i2;
		logic        se;
		logic        de;
	} efc_row_t;
	logic        clock_i, sys_rst_i, wr_en, inj1, inj2, rd_en;
	logic [15:0] wr_data, rd_data_o;
	logic        full_o, near_full_flag_o, threshold_full_flag_o, wr_ack_o, overflow_o, empty_o;
	logic        near_empty_flag_o, threshold_empty_flag_o, valid_o, underflow_o;
	logic        single_error_flag_o, double_error_flag_o;
	logic [4:0]  wr_count_o, rd_count_o;
	logic [15:0] sr_data;
	logic        sr_full, sr_empty, sr_ovf, sr_unf, sr_valid, sr_se, sr_de;
	logic [4:0]  sr_wcnt;
	int          fail_count = 0;
	int          checks = 0;
	efc_row_t    rows [7] = '{'{16'h0000, 1'b0, 1'b0, 1'b0, 1'b0}, '{16'hffff, 1'b1, 1'b0, 1'b1, 1'b0},
		'{16'ha5c3, 1'b0, 1'b0, 1'b0, 1'b0}, '{16'h8000, 1'b0, 1'b1, 1'b0, 1'b1},
		'{16'h3c5a, 1'b1, 1'b1, 1'b0, 1'b1}, '{16'h5555, 1'b0, 1'b0, 1'b0, 1'b0},
		'{16'h0001, 1'b1, 1'b0, 1'b1, 1'b0}};
	efc_user u_usr (.clock_i(clock_i), .wr_en_o(wr_en), .wr_data_o(wr_data), .inj_one_o(inj1),
		.inj_two_o(inj2), .rd_en_o(rd_en));
	efc_fifo #(.DATA_W(16), .DEPTH(16), .PRIM_DEPTH(4), .FULL_THR(12), .EMPTY_THR(2)) i_dut (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .wr_en_i(wr_en), .wr_data_i(wr_data),
		.inject_one_bit_fault_i(inj1), .inject_two_bit_fault_i(inj2), .full_o(full_o),
		.near_full_flag_o(near_full_flag_o), .threshold_full_flag_o(threshold_full_flag_o),
		.wr_ack_o(wr_ack_o), .overflow_o(overflow_o), .wr_count_o(wr_count_o), .rd_en_i(rd_en),
		.rd_data_o(rd_data_o), .empty_o(empty_o), .near_empty_flag_o(near_empty_flag_o),
		.threshold_empty_flag_o(threshold_empty_flag_o), .valid_o(valid_o), .underflow_o(underflow_o),
		.rd_count_o(rd_count_o), .single_error_flag_o(single_error_flag_o),
		.double_error_flag_o(double_error_flag_o));
	// same stimulus into the shift organisation; it carries no code, so injection must be ignored
	efc_fifo #(.DATA_W(16), .DEPTH(16), .PRIM_DEPTH(4), .ORG(efc_pkg::EFC_ORG_SHIFT),
		.ECC_EN(1'b0), .INJ_EN(1'b0), .FULL_THR(12), .EMPTY_THR(2)) i_dut_sr (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .wr_en_i(wr_en), .wr_data_i(wr_data),
		.inject_one_bit_fault_i(inj1), .inject_two_bit_fault_i(inj2), .full_o(sr_full),
		.near_full_flag_o(), .threshold_full_flag_o(), .wr_ack_o(), .overflow_o(sr_ovf),
		.wr_count_o(sr_wcnt), .rd_en_i(rd_en), .rd_data_o(sr_data), .empty_o(sr_empty),
		.near_empty_flag_o(), .threshold_empty_flag_o(), .valid_o(sr_valid), .underflow_o(sr_unf),
		.rd_count_o(), .single_error_flag_o(sr_se), .double_error_flag_o(sr_de));
	// ------
	// tasks
	// ------
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wait_data();
		int k;
		k = 0;
		#1;
		while (empty_o !== 1'b0 && k < 9) begin
			@(posedge clock_i);
			#1;
			k++;
		end
		chk(empty_o, 1'b0);
	endtask : wait_data
	task automatic summarize();
		if (fail_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : summarize
	// ------
	// run
	// ------
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	initial begin
		#20000;
		fail_count++;
		summarize();
	end
	initial begin
		sys_rst_i = 1'b1;
		repeat (3) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		#1;
		chk({empty_o, near_empty_flag_o, threshold_empty_flag_o, full_o}, 4'he);
		for (int i = 0; i < 7; i++) begin
			u_usr.put(rows[i].d, rows[i].i1, rows[i].i2);
			wait_data();
			u_usr.get();
			#1;
			chk(valid_o, 1'b1);
			if (!rows[i].de) begin
				chk(rd_data_o, rows[i].d);
			end
			chk({single_error_flag_o, double_error_flag_o}, {rows[i].se, rows[i].de});
			chk({sr_valid, sr_data, sr_se, sr_de}, {1'b1, rows[i].d, 2'h0});
		end
		@(posedge clock_i);
		sys_rst_i <= 1'b1; // user restart after double errors
		repeat (3) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		#1;
		chk({rd_data_o, single_error_flag_o, double_error_flag_o}, {16'h0001, 2'h2});
		chk({empty_o, wr_count_o, rd_count_o}, 11'h400);
		chk({sr_data, sr_se, sr_de, sr_empty, sr_wcnt}, {16'h0001, 2'h0, 1'b1, 5'h00});
		u_usr.burst(17, 16'h0100);
		#1;
		chk({overflow_o, full_o, near_full_flag_o, threshold_full_flag_o}, 4'hf);
		chk(wr_count_o, 5'h10);
		chk({sr_ovf, sr_full, sr_wcnt}, {2'h3, 5'h10});
		for (int i = 0; i < 16; i++) begin
			u_usr.get();
			#1;
			chk(rd_data_o, 16'h0100 + 16'(i));
			chk({threshold_empty_flag_o, near_empty_flag_o, rd_count_o}, {(15 - i) <= 2, (15 - i) <= 1, 5'(15 - i)});
			chk(sr_data, 16'h0100 + 16'(i));
		end
		u_usr.get();
		#1;
		chk({underflow_o, valid_o, rd_data_o}, {2'h2, 16'h010f});
		chk({sr_unf, sr_valid, sr_data}, {2'h2, 16'h010f});
		summarize();
	end
endmodule : tb
